// >>> include/aocr_pkg.sv
package aocr_pkg;
  // -------------------------------------------------------------------------
  // register page and offsets
  // -------------------------------------------------------------------------
  localparam logic [7:0] PAGE_CFG = 8'h00;
  localparam logic [7:0] OFS_INPUT_SETUP = 8'h3C;
  localparam logic [7:0] OFS_ANALOG_GAIN = 8'h3D;
  localparam logic [7:0] OFS_DIGITAL_VOLUME = 8'h3E;
  localparam logic [7:0] OFS_CALIBRATION = 8'h3F;
  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic [7:0] RST_INPUT_SETUP = 8'h00;
  localparam logic [7:0] RST_ANALOG_GAIN = 8'h00;
  localparam logic [7:0] RST_DIGITAL_VOLUME = 8'hC9;
  localparam logic [7:0] RST_CALIBRATION = 8'h80;
  // -------------------------------------------------------------------------
  // writable bit masks, reserved bits clear
  // -------------------------------------------------------------------------
  localparam logic [7:0] MASK_INPUT_SETUP = 8'hFD;
  localparam logic [7:0] MASK_ANALOG_GAIN = 8'hFC;
  localparam logic [7:0] MASK_DIGITAL_VOLUME = 8'hFF;
  localparam logic [7:0] MASK_CALIBRATION = 8'hF0;
  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int POS_KIND = 7;
  localparam int POS_SRC_HI = 6;
  localparam int POS_SRC_LO = 5;
  localparam int POS_COUPLING = 4;
  localparam int POS_IMP_HI = 3;
  localparam int POS_IMP_LO = 2;
  localparam int POS_BOOST = 0;
  localparam int POS_GAIN_HI = 7;
  localparam int POS_GAIN_LO = 2;
  localparam int POS_TRIM_HI = 7;
  localparam int POS_TRIM_LO = 4;
  localparam int POS_MODE_BIT = 3;
  // -------------------------------------------------------------------------
  // codes
  // -------------------------------------------------------------------------
  localparam logic [1:0] SRC_ANALOG_DIFF = 2'h0;
  localparam logic [1:0] SRC_ANALOG_SE = 2'h1;
  localparam logic [1:0] SRC_PDM = 2'h2;
  localparam logic [1:0] IMP_RESERVED = 2'h3;
  localparam logic [5:0] GAIN_MAX = 6'h2A;
  localparam logic [7:0] VOL_MUTE = 8'h00;
  typedef enum logic [1:0] {
    AOCR_PATH_ANALOG = 2'b01,
    AOCR_PATH_PDM = 2'b10
  } aocr_path_t;
endpackage

// >>> include/aocr_cfg_if.sv
`timescale 1ns/10ps
interface aocr_cfg_if;
  logic [7:0] setup;
  logic [7:0] gain;
  logic [7:0] volume;
  logic [7:0] calib;
  modport bank (output setup, output gain, output volume, output calib);
  modport user (input setup, input gain, input volume, input calib);
endinterface

// >>> rtl/aocr_decode.sv
`timescale 1ns/10ps
module aocr_decode
(
  input wire logic clk_in,
  input wire logic rst_in,
  aocr_cfg_if.user cfg,
  input wire logic mode_bit_in,
  output logic [1:0] path_out,
  output logic kind_line_out,
  output logic dc_coupled_out,
  output logic [1:0] impedance_out,
  output logic range_enhancer_on_out,
  output logic level_control_on_out,
  output logic [5:0] gain_db_out,
  output logic mute_out,
  output logic [7:0] volume_code_out,
  output logic [3:0] trim_code_out
);
  typedef struct packed {
    logic [1:0] path;
    logic kind_line;
    logic dc;
    logic [1:0] imp;
    logic range_enhancer;
    logic alc;
    logic [5:0] gain;
    logic mute;
    logic [7:0] vol;
    logic [3:0] trim;
  } aocr_dec_t;
  aocr_dec_t st_r;
  aocr_dec_t st_nxt;
  logic [1:0] src;
  logic analog;
  // -------------------------------------------------------------------------
  // datapath steering
  // -------------------------------------------------------------------------
  always_comb
  begin
    src = cfg.setup[aocr_pkg::POS_SRC_HI:aocr_pkg::POS_SRC_LO];
    analog = (src == aocr_pkg::SRC_ANALOG_DIFF) || (src == aocr_pkg::SRC_ANALOG_SE);
    st_nxt = st_r;
    // reserved source code drives neither path
    st_nxt.path = analog ? aocr_pkg::AOCR_PATH_ANALOG :
      (src == aocr_pkg::SRC_PDM) ? aocr_pkg::AOCR_PATH_PDM : 2'h0; // [R2]
    st_nxt.kind_line = cfg.setup[aocr_pkg::POS_KIND]; // [R1]
    // coupling and impedance only matter on analog inputs
    st_nxt.dc = analog & cfg.setup[aocr_pkg::POS_COUPLING]; // [R5]
    st_nxt.imp = analog ? cfg.setup[aocr_pkg::POS_IMP_HI:aocr_pkg::POS_IMP_LO] : 2'h0; // [R6]
    st_nxt.range_enhancer = cfg.setup[aocr_pkg::POS_BOOST] & ~mode_bit_in; // [R7]
    st_nxt.alc = cfg.setup[aocr_pkg::POS_BOOST] & mode_bit_in; // [R7]
    st_nxt.gain = cfg.gain[aocr_pkg::POS_GAIN_HI:aocr_pkg::POS_GAIN_LO]; // [R8]
    // reserved gain codes clamp to the top step, a safe choice
    if (st_nxt.gain > aocr_pkg::GAIN_MAX)
    begin
      st_nxt.gain = aocr_pkg::GAIN_MAX; // [R8]
    end
    st_nxt.mute = (cfg.volume == aocr_pkg::VOL_MUTE); // [R9]
    st_nxt.vol = cfg.volume; // [R10]
    st_nxt.trim = cfg.calib[aocr_pkg::POS_TRIM_HI:aocr_pkg::POS_TRIM_LO]; // [R15]
  end
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_r <= '0;
      st_r.path <= aocr_pkg::AOCR_PATH_ANALOG;
      st_r.vol <= aocr_pkg::RST_DIGITAL_VOLUME;
      st_r.trim <= aocr_pkg::RST_CALIBRATION[aocr_pkg::POS_TRIM_HI:aocr_pkg::POS_TRIM_LO];
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
  assign path_out = st_r.path;
  assign kind_line_out = st_r.kind_line;
  assign dc_coupled_out = st_r.dc;
  assign impedance_out = st_r.imp;
  assign range_enhancer_on_out = st_r.range_enhancer;
  assign level_control_on_out = st_r.alc;
  assign gain_db_out = st_r.gain;
  assign mute_out = st_r.mute;
  assign volume_code_out = st_r.vol;
  assign trim_code_out = st_r.trim;
endmodule // aocr_decode

// >>> rtl/aocr_regs.sv
`timescale 1ns/10ps
// Notes on behaviour
// R1: bit 7 picks microphone or line input
// R2: bits 6-5 pick differential, single-ended or PDM
// R3: software disables channel-one pins for analog
// R4: software sets pins for PDM data, clock
// R5: bit 4 picks AC or DC, analog only
// R6: bits 3-2 pick input impedance
// R7: bit 0 enables enhancer or level control
// R8: gain code 0 to 42 in dB
// R9: volume code zero mutes output
// R10: volume codes 1-255 in half-dB steps
// R11: volume register resets to C9h
// R12: setup register at 3Ch resets zero
// R13: gain register at 3Dh resets zero
// R14: calibration register at 3Fh resets 80h
// R15: upper nibble trims gain, 8 is zero
// R16: reserved bits read zero, ignore writes
// R17: software avoids writing reserved codes
module aocr_regs
(
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic [7:0] REG_PAGE_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  output logic [7:0] REG_RDATA_OUT,
  output logic REG_HIT_OUT,
  input wire logic GLOBAL_RANGE_MODE_IN,
  output logic [1:0] PATH_OUT,
  output logic KIND_LINE_OUT,
  output logic DC_COUPLED_OUT,
  output logic [1:0] IMPEDANCE_OUT,
  output logic RANGE_ENHANCER_ON_OUT,
  output logic LEVEL_CONTROL_ON_OUT,
  output logic [5:0] GAIN_DB_OUT,
  output logic MUTE_OUT,
  output logic [7:0] VOLUME_CODE_OUT,
  output logic [3:0] TRIM_CODE_OUT
);
  typedef struct packed {
    logic [7:0] setup;
    logic [7:0] gain;
    logic [7:0] volume;
    logic [7:0] calib;
  } aocr_bank_t;
  aocr_bank_t st_r;
  aocr_bank_t st_nxt;
  aocr_cfg_if cfg_bus ();
  // -------------------------------------------------------------------------
  // address decode
  // -------------------------------------------------------------------------
  function automatic logic at_ofs(input logic [7:0] page, input logic [7:0] addr,
                                  input logic [7:0] ofs);
    at_ofs = (page == aocr_pkg::PAGE_CFG) && (addr == ofs);
  endfunction
  // -------------------------------------------------------------------------
  // write path
  // -------------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    if (REG_WR_IN)
    begin
      // reserved bits masked off on every write
      if (at_ofs(REG_PAGE_IN, REG_ADDR_IN, aocr_pkg::OFS_INPUT_SETUP))
      begin
        st_nxt.setup = REG_WDATA_IN & aocr_pkg::MASK_INPUT_SETUP; // [R16]
      end
      if (at_ofs(REG_PAGE_IN, REG_ADDR_IN, aocr_pkg::OFS_ANALOG_GAIN))
      begin
        st_nxt.gain = REG_WDATA_IN & aocr_pkg::MASK_ANALOG_GAIN; // [R16]
      end
      if (at_ofs(REG_PAGE_IN, REG_ADDR_IN, aocr_pkg::OFS_DIGITAL_VOLUME))
      begin
        st_nxt.volume = REG_WDATA_IN & aocr_pkg::MASK_DIGITAL_VOLUME;
      end
      if (at_ofs(REG_PAGE_IN, REG_ADDR_IN, aocr_pkg::OFS_CALIBRATION))
      begin
        st_nxt.calib = REG_WDATA_IN & aocr_pkg::MASK_CALIBRATION; // [R16]
      end
    end
  end
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      st_r.setup <= aocr_pkg::RST_INPUT_SETUP; // [R12]
      st_r.gain <= aocr_pkg::RST_ANALOG_GAIN; // [R13]
      st_r.volume <= aocr_pkg::RST_DIGITAL_VOLUME; // [R11]
      st_r.calib <= aocr_pkg::RST_CALIBRATION; // [R14]
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
  // -------------------------------------------------------------------------
  // read path, combinational; unmapped reads zero
  // -------------------------------------------------------------------------
  always_comb
  begin
    REG_RDATA_OUT = 8'h00;
    REG_HIT_OUT = 1'b1;
    if (at_ofs(REG_PAGE_IN, REG_ADDR_IN, aocr_pkg::OFS_INPUT_SETUP))
    begin
      REG_RDATA_OUT = st_r.setup;
    end
    else if (at_ofs(REG_PAGE_IN, REG_ADDR_IN, aocr_pkg::OFS_ANALOG_GAIN))
    begin
      REG_RDATA_OUT = st_r.gain;
    end
    else if (at_ofs(REG_PAGE_IN, REG_ADDR_IN, aocr_pkg::OFS_DIGITAL_VOLUME))
    begin
      REG_RDATA_OUT = st_r.volume;
    end
    else if (at_ofs(REG_PAGE_IN, REG_ADDR_IN, aocr_pkg::OFS_CALIBRATION))
    begin
      REG_RDATA_OUT = st_r.calib;
    end
    else
    begin
      REG_HIT_OUT = 1'b0;
    end
  end
  assign cfg_bus.setup = st_r.setup;
  assign cfg_bus.gain = st_r.gain;
  assign cfg_bus.volume = st_r.volume;
  assign cfg_bus.calib = st_r.calib;
  // -------------------------------------------------------------------------
  // datapath controls; pin muxing left to software
  // -------------------------------------------------------------------------
  aocr_decode u_decode
  (
    .clk_in(CORE_CLK_IN),
    .rst_in(SYS_RST_IN),
    .cfg(cfg_bus.user),
    .mode_bit_in(GLOBAL_RANGE_MODE_IN),
    .path_out(PATH_OUT),
    .kind_line_out(KIND_LINE_OUT),
    .dc_coupled_out(DC_COUPLED_OUT),
    .impedance_out(IMPEDANCE_OUT),
    .range_enhancer_on_out(RANGE_ENHANCER_ON_OUT),
    .level_control_on_out(LEVEL_CONTROL_ON_OUT),
    .gain_db_out(GAIN_DB_OUT),
    .mute_out(MUTE_OUT),
    .volume_code_out(VOLUME_CODE_OUT),
    .trim_code_out(TRIM_CODE_OUT)
  );
endmodule // aocr_regs

// >>> dv/aocr_regs_assertions.sv
`timescale 1ns/10ps
module aocr_regs_assertions
(
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic [7:0] REG_PAGE_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic REG_HIT_OUT,
  input wire logic [1:0] PATH_OUT,
  input wire logic DC_COUPLED_OUT,
  input wire logic RANGE_ENHANCER_ON_OUT,
  input wire logic LEVEL_CONTROL_ON_OUT,
  input wire logic [5:0] GAIN_DB_OUT,
  input wire logic MUTE_OUT,
  input wire logic [7:0] VOLUME_CODE_OUT
);
  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  AST_HIT_MAP: assert property (
    REG_HIT_OUT == (REG_PAGE_IN == 8'h00 && REG_ADDR_IN[7:2] == 6'h0F))
    else $error("hit flag wrong");
  AST_UNMAPPED_ZERO: assert property (!REG_HIT_OUT |-> REG_RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  AST_RSVD_CAL: assert property (
    REG_HIT_OUT && REG_ADDR_IN == 8'h3F |-> REG_RDATA_OUT[3:0] == 4'h0)
    else $error("reserved trim bits set");
  // second edge because decoded outputs lag the register by one
  AST_VOL_WRITE: assert property (
    REG_WR_IN && REG_HIT_OUT && REG_ADDR_IN == 8'h3E ##1 !REG_WR_IN
    |=> VOLUME_CODE_OUT == $past(REG_WDATA_IN, 2))
    else $error("volume code not taken");
  AST_MUTE: assert property (MUTE_OUT == (VOLUME_CODE_OUT == 8'h00))
    else $error("mute wrong");
  AST_BOOST_ONE: assert property (!(RANGE_ENHANCER_ON_OUT && LEVEL_CONTROL_ON_OUT))
    else $error("both boost modes on");
  AST_GAIN_MAX: assert property (GAIN_DB_OUT <= 6'h2A)
    else $error("gain above max");
  AST_PDM_AC: assert property (PATH_OUT == 2'b10 |-> !DC_COUPLED_OUT)
    else $error("coupling on pdm");
  AST_PATH_LEGAL: assert property (PATH_OUT != 2'b11)
    else $error("illegal path");
  cover property (REG_WR_IN && REG_HIT_OUT);
  cover property (MUTE_OUT);
  cover property (PATH_OUT == 2'b10);
endmodule // aocr_regs_assertions
bind aocr_regs aocr_regs_assertions u_chk (.CORE_CLK_IN(CORE_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
  .REG_PAGE_IN(REG_PAGE_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_WR_IN(REG_WR_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .REG_HIT_OUT(REG_HIT_OUT),
  .PATH_OUT(PATH_OUT), .DC_COUPLED_OUT(DC_COUPLED_OUT), .GAIN_DB_OUT(GAIN_DB_OUT),
  .RANGE_ENHANCER_ON_OUT(RANGE_ENHANCER_ON_OUT), .LEVEL_CONTROL_ON_OUT(LEVEL_CONTROL_ON_OUT),
  .MUTE_OUT(MUTE_OUT), .VOLUME_CODE_OUT(VOLUME_CODE_OUT));

// >>> dv/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] pg = 8'h00;
  logic [7:0] ad = 8'h00;
  logic wr = 1'b0;
  logic [7:0] wd = 8'h00;
  logic mode = 1'b0;
  logic [7:0] rd;
  logic hit;
  logic [1:0] path;
  logic kind;
  logic dc;
  logic [1:0] imp;
  logic range_enhancer;
  logic automatic_level_control;
  logic [5:0] gain;
  logic mute;
  logic [7:0] vol;
  logic [3:0] trim;
  int num_errors = 0;
  int tests_run = 0;
  logic [7:0] rv[4] = '{8'h00, 8'h00, 8'hC9, 8'h80};
  logic [7:0] mk[4] = '{8'hFD, 8'hFC, 8'hFF, 8'hF0};
  always #5 clk = ~clk;
  aocr_regs uut (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .REG_PAGE_IN(pg), .REG_ADDR_IN(ad),
    .REG_WR_IN(wr), .REG_WDATA_IN(wd), .REG_RDATA_OUT(rd), .REG_HIT_OUT(hit),
    .GLOBAL_RANGE_MODE_IN(mode), .PATH_OUT(path), .KIND_LINE_OUT(kind), .DC_COUPLED_OUT(dc),
    .IMPEDANCE_OUT(imp), .RANGE_ENHANCER_ON_OUT(range_enhancer), .LEVEL_CONTROL_ON_OUT(automatic_level_control),
    .GAIN_DB_OUT(gain), .MUTE_OUT(mute), .VOLUME_CODE_OUT(vol), .TRIM_CODE_OUT(trim));
  // --------------------------------------------------------------
  // access tasks
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    tests_run++;
    if (got !== ex)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // returns after decoded outputs have settled
  task automatic wr_reg(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    pg <= p;
    ad <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] p, input logic [7:0] a, input logic [7:0] ex);
    @(posedge clk);
    pg <= p;
    ad <= a;
    #1;
    chk("read", ex, rd);
    chk("hit", 8'(p == 8'h00 && a[7:2] == 6'h0F), 8'(hit));
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rd_chk(8'h00, 8'h3C + 8'(i), rv[i]);
    chk("trim", 8'h08, 8'(trim));
    $display("reset values done");
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(8'h00, 8'h3C + 8'(i), 8'hFF);
      rd_chk(8'h00, 8'h3C + 8'(i), mk[i]);
    end
    rd_chk(8'h00, 8'h3B, 8'h00);
    wr_reg(8'h01, 8'h3E, 8'h00);
    rd_chk(8'h01, 8'h3E, 8'h00);
    rd_chk(8'h00, 8'h3E, 8'hFF);
    chk("rsvd path", 8'h00, 8'(path));
    chk("rsvd imp", 8'h00, 8'(imp));
    chk("gain clamp", 8'h2A, 8'(gain));
    $display("masks done");
    for (int s = 0; s < 3; s++)
    begin
      // legal codes only; pin set-up is software's side
      wr_reg(8'h00, 8'h3C, {1'b1, 2'(s), 1'b1, 2'b10, 1'b0, 1'b1});
      chk("path", (s == 2) ? 8'h02 : 8'h01, 8'(path));
      chk("kind", 8'h01, 8'(kind));
      chk("dc", (s == 2) ? 8'h00 : 8'h01, 8'(dc));
      chk("imp", (s == 2) ? 8'h00 : 8'h02, 8'(imp));
      chk("boost", 8'h01, 8'({automatic_level_control, range_enhancer}));
    end
    @(posedge clk);
    mode <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("level", 8'h02, 8'({automatic_level_control, range_enhancer}));
    wr_reg(8'h00, 8'h3C, 8'h00);
    chk("off", 8'h00, 8'({automatic_level_control, range_enhancer}));
    wr_reg(8'h00, 8'h3D, 8'hAB);
    chk("gain", 8'h2A, 8'(gain));
    wr_reg(8'h00, 8'h3D, 8'h04);
    chk("gain", 8'h01, 8'(gain));
    wr_reg(8'h00, 8'h3E, 8'h00);
    chk("mute", 8'h01, 8'(mute));
    wr_reg(8'h00, 8'h3E, 8'h01);
    chk("vol", 8'h01, vol);
    chk("unmute", 8'h00, 8'(mute));
    wr_reg(8'h00, 8'h3F, 8'h3F);
    chk("trim", 8'h03, 8'(trim));
    $display("fields done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("vol", 8'hC9, vol);
    rd_chk(8'h00, 8'h3F, 8'h80);
    $display("second reset done");
    end_of_test();
  end
endmodule // testbench
